/* logic/sss_top.v */
`include "sss_consts.vh"

module sss_top #(
	parameter [38:0] CYC_PER_HOUR = `SSS_CYC_PER_HOUR,
	parameter BLINK_HALF_CYC = `SSS_BLINK_HALF_CYC,
	parameter [7:0] DERATE_TEMP = `SSS_DERATE_TEMP,
	parameter [7:0] WARN_MARGIN = `SSS_WARN_MARGIN
) (
	// clock and reset
	input wire mclk,
	input wire rst,
	// measurements, percent of set or nominal (temp_c in degrees C), same clock
	input wire [7:0] vout_pct,
	input wire [7:0] iout_pct,
	input wire [7:0] pout_pct,
	input wire [7:0] vin_pct,
	input wire [7:0] temp_c,
	// asynchronous pins
	input wire output_overvoltage_limiter,
	input wire remote_off_pin,
	// configuration, captured on cfg_wr
	input wire cfg_wr,
	input wire [7:0] cfg_vout_thr,
	input wire [7:0] cfg_iout_thr,
	input wire [7:0] cfg_pout_thr,
	input wire [7:0] cfg_vin_thr,
	input wire [23:0] cfg_hours_lim,
	input wire [6:0] cfg_out1_mask,
	input wire cfg_out1_and,
	input wire cfg_out1_inv,
	input wire [6:0] cfg_out2_mask,
	input wire cfg_out2_and,
	input wire cfg_out2_inv,
	input wire [6:0] cfg_relay_mask,
	input wire cfg_relay_and,
	input wire cfg_relay_inv,
	input wire cfg_out2_analog,
	input wire [1:0] cfg_ana_src,
	input wire [7:0] cfg_ana_full,
	// status outputs
	output reg out1_ff,
	output reg out2_ff,
	output reg [15:0] out2_ua_ff,
	output reg relay_closed_ff,
	// front lamps
	output reg output_good_lamp_ff,
	output reg lamp_vin_ff,
	output reg lamp_bar1_ff,
	output reg lamp_bar2_ff,
	output reg lamp_bar3_ff,
	// power stage and status
	output reg power_en_ff,
	output reg boost_ff,
	output reg derate_ff,
	output reg [6:0] cond_ff,
	output reg [23:0] hours_ff
);

	////////////////////////////////////////////////////////////////////////
	// helpers

	function [7:0] clamp;
		input [7:0] v;
		input [7:0] lo;
		input [7:0] hi;
		begin
			if (v < lo) begin
				clamp = lo;
			end else if (v > hi) begin
				clamp = hi;
			end else begin
				clamp = v;
			end
		end
	endfunction

	// masked and/or over the condition vector, then optional inversion
	function combine;
		input [6:0] mask;
		input [6:0] cond;
		input use_and;
		input inv;
		begin
			if (mask == 7'h00) begin
				combine = inv;
			end else if (use_and) begin
				combine = (&(cond | ~mask)) ^ inv;
			end else begin
				combine = (|(cond & mask)) ^ inv;
			end
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// configuration store

	reg [7:0] vout_thr_ff;
	reg [7:0] iout_thr_ff;
	reg [7:0] pout_thr_ff;
	reg [7:0] vin_thr_ff;
	reg [23:0] hours_lim_ff;
	reg [6:0] out1_mask_ff;
	reg out1_and_ff;
	reg out1_inv_ff;
	reg [6:0] out2_mask_ff;
	reg out2_and_ff;
	reg out2_inv_ff;
	reg [6:0] relay_mask_ff;
	reg relay_and_ff;
	reg relay_inv_ff;
	reg out2_analog_ff;
	reg [1:0] ana_src_ff;
	reg [7:0] ana_full_ff;

	always @(posedge mclk) begin
		if (rst) begin
			vout_thr_ff <= `SSS_VOUT_THR_DEF;
			iout_thr_ff <= `SSS_IP_THR_DEF;
			pout_thr_ff <= `SSS_IP_THR_DEF;
			vin_thr_ff <= `SSS_VIN_THR_DEF;
			hours_lim_ff <= `SSS_HOURS_DEF;
			out1_mask_ff <= `SSS_OUT1_MASK_DEF;
			out1_and_ff <= 1'b0;
			out1_inv_ff <= 1'b0;
			out2_mask_ff <= `SSS_OUT2_MASK_DEF;
			out2_and_ff <= 1'b0;
			out2_inv_ff <= 1'b0;
			// closed while output good, opens on undershoot
			relay_mask_ff <= `SSS_RELAY_MASK_DEF;
			relay_and_ff <= 1'b0;
			relay_inv_ff <= 1'b1;
			out2_analog_ff <= 1'b0;
			ana_src_ff <= `SSS_SRC_VOUT;
			ana_full_ff <= `SSS_ANA_FULL_DEF;
		end else if (cfg_wr) begin
			// out of range vout, iout and pout thresholds are pulled to the nearest limit
			vout_thr_ff <= clamp(cfg_vout_thr, `SSS_VOUT_THR_MIN,
				`SSS_VOUT_THR_MAX);
			iout_thr_ff <= clamp(cfg_iout_thr, `SSS_IP_THR_MIN,
				`SSS_IP_THR_MAX);
			pout_thr_ff <= clamp(cfg_pout_thr, `SSS_IP_THR_MIN,
				`SSS_IP_THR_MAX);
			vin_thr_ff <= cfg_vin_thr;
			hours_lim_ff <= cfg_hours_lim;
			out1_mask_ff <= cfg_out1_mask;
			out1_and_ff <= cfg_out1_and;
			out1_inv_ff <= cfg_out1_inv;
			out2_mask_ff <= cfg_out2_mask;
			out2_and_ff <= cfg_out2_and;
			out2_inv_ff <= cfg_out2_inv;
			relay_mask_ff <= cfg_relay_mask;
			relay_and_ff <= cfg_relay_and;
			relay_inv_ff <= cfg_relay_inv;
			out2_analog_ff <= cfg_out2_analog;
			// only voltage, current and power feed the analog output
			if (cfg_ana_src == `SSS_SRC_IOUT ||
				cfg_ana_src == `SSS_SRC_POUT) begin
				ana_src_ff <= cfg_ana_src;
			end else begin
				ana_src_ff <= `SSS_SRC_VOUT;
			end
			ana_full_ff <= cfg_ana_full;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pins

	wire limiter_lvl;
	wire remote_off_lvl;

	sss_sync u_sync_limit (
		.mclk(mclk),
		.rst(rst),
		.pin_in(output_overvoltage_limiter),
		.level_ff(limiter_lvl)
	);

	sss_sync u_sync_rem (
		.mclk(mclk),
		.rst(rst),
		.pin_in(remote_off_pin),
		.level_ff(remote_off_lvl)
	);

	wire blink;

	sss_blink #(
		.HALF_CYC(BLINK_HALF_CYC)
	) u_blink (
		.mclk(mclk),
		.rst(rst),
		.blink_ff(blink)
	);

	////////////////////////////////////////////////////////////////////////
	// operating hours

	reg [38:0] cyc_ff;

	// hour count saturates, so a long run never wraps back to zero
	always @(posedge mclk) begin
		if (rst) begin
			cyc_ff <= 39'h0000000000;
			hours_ff <= 24'h000000;
		end else if (cyc_ff >= CYC_PER_HOUR - 39'h0000000001) begin
			cyc_ff <= 39'h0000000000;
			if (hours_ff != `SSS_HOURS_INF) begin
				hours_ff <= hours_ff + 24'h000001;
			end
		end else begin
			cyc_ff <= cyc_ff + 39'h0000000001;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// conditions

	reg [6:0] nxt_cond;
	wire sleep = remote_off_lvl;

	always @* begin
		nxt_cond = 7'h00;
		nxt_cond[`SSS_C_VOUT] = vout_pct < vout_thr_ff;
		nxt_cond[`SSS_C_IOUT] = iout_pct > iout_thr_ff;
		nxt_cond[`SSS_C_POUT] = pout_pct > pout_thr_ff;
		// all-ones limit means never
		nxt_cond[`SSS_C_HOURS] = (hours_lim_ff != `SSS_HOURS_INF) &&
			(hours_ff >= hours_lim_ff);
		// margin keeps the warning ahead of derating
		nxt_cond[`SSS_C_TEMP] = temp_c >= (DERATE_TEMP - WARN_MARGIN);
		nxt_cond[`SSS_C_LIMIT] = limiter_lvl;
		nxt_cond[`SSS_C_VIN] = vin_pct < vin_thr_ff;
	end

	////////////////////////////////////////////////////////////////////////
	// analog scaling

	reg [7:0] ana_val;
	reg [21:0] ana_num;
	reg [21:0] ana_quo;
	reg [15:0] nxt_ua;

	always @* begin
		ana_num = 22'h000000;
		ana_quo = 22'h000000;
		case (ana_src_ff)
			`SSS_SRC_IOUT: ana_val = iout_pct;
			`SSS_SRC_POUT: ana_val = pout_pct;
			default: ana_val = vout_pct;
		endcase
		if (ana_val > ana_full_ff) begin
			ana_val = ana_full_ff;
		end
		if (ana_full_ff == 8'h00) begin
			nxt_ua = `SSS_UA_MIN;
		end else begin
			ana_num = `SSS_UA_SPAN * {14'h0000, ana_val};
			ana_quo = ana_num / {14'h0000, ana_full_ff};
			nxt_ua = `SSS_UA_MIN + ana_quo[15:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs and lamps

	always @(posedge mclk) begin
		if (rst) begin
			cond_ff <= 7'h00;
			out1_ff <= 1'b0;
			out2_ff <= 1'b0;
			out2_ua_ff <= 16'h0000;
			relay_closed_ff <= 1'b0;
			output_good_lamp_ff <= 1'b0;
			lamp_vin_ff <= 1'b0;
			lamp_bar1_ff <= 1'b0;
			lamp_bar2_ff <= 1'b0;
			lamp_bar3_ff <= 1'b0;
			power_en_ff <= 1'b0;
			boost_ff <= 1'b0;
			derate_ff <= 1'b0;
		end else begin
			cond_ff <= nxt_cond;
			derate_ff <= temp_c >= DERATE_TEMP;
			power_en_ff <= ~sleep;
			if (sleep) begin
				// output-off: everything except derate, conditions and hours dark, low and open
				out1_ff <= 1'b0;
				out2_ff <= 1'b0;
				out2_ua_ff <= 16'h0000;
				relay_closed_ff <= 1'b0;
				output_good_lamp_ff <= 1'b0;
				lamp_vin_ff <= 1'b0;
				lamp_bar1_ff <= 1'b0;
				lamp_bar2_ff <= 1'b0;
				lamp_bar3_ff <= 1'b0;
				boost_ff <= 1'b0;
			end else begin
				out1_ff <= combine(out1_mask_ff, nxt_cond,
					out1_and_ff, out1_inv_ff);
				if (out2_analog_ff) begin
					out2_ff <= 1'b0;
					out2_ua_ff <= nxt_ua;
				end else begin
					out2_ff <= combine(out2_mask_ff, nxt_cond,
						out2_and_ff, out2_inv_ff);
					out2_ua_ff <= 16'h0000;
				end
				relay_closed_ff <= combine(relay_mask_ff, nxt_cond,
					relay_and_ff, relay_inv_ff);
				if (vout_pct >= `SSS_LAMP_DCOK) begin
					output_good_lamp_ff <= 1'b1;
				end else begin
					output_good_lamp_ff <= blink;
				end
				lamp_vin_ff <= vin_pct < `SSS_LAMP_VIN;
				// bars are cumulative: higher implies lower
				lamp_bar1_ff <= pout_pct > `SSS_LAMP_BAR1;
				lamp_bar2_ff <= pout_pct > `SSS_LAMP_BAR2;
				boost_ff <= pout_pct > `SSS_LAMP_BOOST;
				lamp_bar3_ff <= pout_pct > `SSS_LAMP_BOOST;
			end
		end
	end

endmodule

/* logic/sss_consts.vh */
`ifndef SSS_CONSTS_VH
`define SSS_CONSTS_VH

// clock rate and derived time bases
`define SSS_CLK_KHZ 125000
`define SSS_BLINK_HALF_MS 500
`define SSS_BLINK_HALF_CYC (`SSS_CLK_KHZ * `SSS_BLINK_HALF_MS)
`define SSS_HOUR_S 39'd3600
`define SSS_CLK_HZ 39'd125000000
`define SSS_CYC_PER_HOUR (`SSS_CLK_HZ * `SSS_HOUR_S)

// monitored condition bit positions
`define SSS_C_VOUT 0
`define SSS_C_IOUT 1
`define SSS_C_POUT 2
`define SSS_C_HOURS 3
`define SSS_C_TEMP 4
`define SSS_C_LIMIT 5
`define SSS_C_VIN 6
`define SSS_NCOND 7

// threshold ranges and defaults, percent (hours limit in hours)
`define SSS_VOUT_THR_MIN 8'h19
`define SSS_VOUT_THR_MAX 8'h87
`define SSS_VOUT_THR_DEF 8'h5A
`define SSS_IP_THR_MIN 8'h05
`define SSS_IP_THR_MAX 8'h96
`define SSS_IP_THR_DEF 8'h64
`define SSS_VIN_THR_DEF 8'h50
`define SSS_HOURS_DEF 24'h015630
`define SSS_HOURS_INF 24'hFFFFFF

// default routing
`define SSS_OUT1_MASK_DEF 7'h40
`define SSS_OUT2_MASK_DEF 7'h04
`define SSS_RELAY_MASK_DEF 7'h01

// analog output
`define SSS_SRC_VOUT 2'h0
`define SSS_SRC_IOUT 2'h1
`define SSS_SRC_POUT 2'h2
`define SSS_ANA_FULL_DEF 8'h7D
`define SSS_UA_MIN 16'h0FA0
`define SSS_UA_SPAN 22'h003E80

// fixed lamp thresholds, percent
`define SSS_LAMP_DCOK 8'h5A
`define SSS_LAMP_VIN 8'h50
`define SSS_LAMP_BAR1 8'h32
`define SSS_LAMP_BAR2 8'h4B
`define SSS_LAMP_BOOST 8'h64

// temperature, degrees C
`define SSS_DERATE_TEMP 8'h3C
`define SSS_WARN_MARGIN 8'h05

`endif

/* logic/sss_sync.v */
`include "sss_consts.vh"

module sss_sync (
	// clock and reset
	input wire mclk,
	input wire rst,
	// pin side
	input wire pin_in,
	// clean level
	output reg level_ff
);

	reg s1_ff;
	reg s2_ff;
	reg s3_ff;

	// level only moves once two later stages agree
	always @(posedge mclk) begin
		if (rst) begin
			s1_ff <= 1'b0;
			s2_ff <= 1'b0;
			s3_ff <= 1'b0;
			level_ff <= 1'b0;
		end else begin
			s1_ff <= pin_in;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			if (s2_ff == s3_ff) begin
				level_ff <= s3_ff;
			end
		end
	end

endmodule

/* logic/sss_blink.v */
`include "sss_consts.vh"

module sss_blink #(
	parameter HALF_CYC = `SSS_BLINK_HALF_CYC
) (
	// clock and reset
	input wire mclk,
	input wire rst,
	// square wave, half period HALF_CYC cycles
	output reg blink_ff
);

	reg [31:0] cnt_ff;

	always @(posedge mclk) begin
		if (rst) begin
			cnt_ff <= 32'h00000000;
			blink_ff <= 1'b0;
		end else if (cnt_ff >= HALF_CYC - 1) begin
			cnt_ff <= 32'h00000000;
			blink_ff <= ~blink_ff;
		end else begin
			cnt_ff <= cnt_ff + 32'h00000001;
		end
	end

endmodule

/* bench/sss_chk.sv */
module sss_chk #(
	parameter BLINK_HALF_CYC = 4
) (
	// clock and reset
	input wire mclk,
	input wire rst,
	// inputs watched
	input wire [7:0] vout_pct,
	input wire [7:0] pout_pct,
	input wire [7:0] vin_pct,
	input wire output_overvoltage_limiter,
	input wire remote_off_pin,
	// outputs watched
	input wire out1_ff,
	input wire out2_ff,
	input wire [15:0] out2_ua_ff,
	input wire relay_closed_ff,
	input wire output_good_lamp_ff,
	input wire lamp_vin_ff,
	input wire lamp_bar1_ff,
	input wire lamp_bar2_ff,
	input wire lamp_bar3_ff,
	input wire power_en_ff,
	input wire boost_ff,
	input wire [6:0] cond_ff,
	input wire [23:0] hours_ff
);
	timeunit 1ns;
	timeprecision 1ps;
	reg [7:0] vout_q_ff;
	reg lamp_q_ff;
	reg [31:0] run_ff;
	wire dim;

	default clocking @(posedge mclk); endclocking
	default disable iff (rst);

	////////////////////////////////////////////////////////////////////
	// length of each steady stretch of the lamp while output is low
	assign dim = power_en_ff && vout_q_ff < 8'h5A;
	always @(posedge mclk) begin
		vout_q_ff <= vout_pct;
		lamp_q_ff <= output_good_lamp_ff;
		if (rst || !dim)
			run_ff <= 32'h0;
		else if (run_ff == 32'h0 || output_good_lamp_ff != lamp_q_ff)
			run_ff <= 32'h1;
		else
			run_ff <= run_ff + 32'h1;
	end

	////////////////////////////////////////////////////////////////////
	sequence s_on;
		power_en_ff;
	endsequence
	// pins pass a synchroniser, so they must hold a few cycles first
	sequence s_off_req;
		$rose(remote_off_pin) ##1 remote_off_pin [*2];
	endsequence
	sequence s_on_req;
		$fell(remote_off_pin) ##1 !remote_off_pin [*2];
	endsequence
	sequence s_lim_up;
		$rose(output_overvoltage_limiter) ##1 output_overvoltage_limiter [*2];
	endsequence

	property p_bar1;
		s_on |-> lamp_bar1_ff == ($past(pout_pct) > 8'h32);
	endproperty
	property p_bar2;
		s_on |-> lamp_bar2_ff == ($past(pout_pct) > 8'h4B)
			&& (!lamp_bar2_ff || lamp_bar1_ff);
	endproperty
	property p_boost;
		s_on |-> boost_ff == ($past(pout_pct) > 8'h64)
			&& lamp_bar3_ff == boost_ff;
	endproperty
	property p_vin_lamp;
		s_on |-> lamp_vin_ff == ($past(vin_pct) < 8'h50);
	endproperty
	property p_good;
		power_en_ff && $past(vout_pct) >= 8'h5A |-> output_good_lamp_ff;
	endproperty
	property p_blink;
		run_ff <= BLINK_HALF_CYC;
	endproperty
	property p_sleep;
		!power_en_ff |-> !(out1_ff | out2_ff | relay_closed_ff | boost_ff
			| output_good_lamp_ff | lamp_vin_ff | lamp_bar1_ff
			| lamp_bar2_ff | lamp_bar3_ff) && out2_ua_ff == 16'h0000;
	endproperty
	property p_off;
		s_off_req |-> ##[1:4] !power_en_ff;
	endproperty
	property p_resume;
		s_on_req |-> ##[1:4] power_en_ff;
	endproperty
	property p_lim;
		s_lim_up |-> ##[1:4] cond_ff[5];
	endproperty
	property p_hours;
		$changed(hours_ff) |-> hours_ff == $past(hours_ff) + 24'h000001;
	endproperty

	a_bar1: assert property (p_bar1) else $error("bar1 lamp wrong");
	a_bar2: assert property (p_bar2) else $error("bar2 lamp wrong");
	a_boost: assert property (p_boost) else $error("boost wrong");
	a_vin_lamp: assert property (p_vin_lamp) else $error("vin lamp");
	a_good: assert property (p_good) else $error("good lamp dark");
	a_blink: assert property (p_blink) else $error("no blink");
	a_sleep: assert property (p_sleep) else $error("sleep outputs");
	a_off: assert property (p_off) else $error("no switch off");
	a_resume: assert property (p_resume) else $error("no resume");
	a_lim: assert property (p_lim) else $error("limiter missed");
	a_hours: assert property (p_hours) else $error("hours step");
endmodule

bind sss_top sss_chk #(.BLINK_HALF_CYC(BLINK_HALF_CYC)) u_chk (
	.mclk(mclk), .rst(rst), .vout_pct(vout_pct), .pout_pct(pout_pct),
	.vin_pct(vin_pct), .output_overvoltage_limiter(output_overvoltage_limiter),
	.remote_off_pin(remote_off_pin), .out1_ff(out1_ff), .out2_ff(out2_ff),
	.out2_ua_ff(out2_ua_ff), .relay_closed_ff(relay_closed_ff),
	.output_good_lamp_ff(output_good_lamp_ff), .lamp_vin_ff(lamp_vin_ff),
	.lamp_bar1_ff(lamp_bar1_ff), .lamp_bar2_ff(lamp_bar2_ff),
	.lamp_bar3_ff(lamp_bar3_ff), .power_en_ff(power_en_ff),
	.boost_ff(boost_ff), .cond_ff(cond_ff), .hours_ff(hours_ff)
);

/* bench/sss_plc.sv */
module sss_plc (
	// clock
	input wire mclk,
	// controller program request and output stage delay
	input wire off_req,
	input wire [3:0] lag,
	// remote pin, high puts the supply to sleep
	output wire remote_off_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt_ff = 4'h0;
	logic pin_ff = 1'b0;

	assign remote_off_pin = pin_ff;
	// a slow output card lets the pin follow only lag+1 cycles later
	always @(posedge mclk) begin
		if (off_req == pin_ff)
			cnt_ff <= 4'h0;
		else if (cnt_ff >= lag)
			pin_ff <= off_req;
		else
			cnt_ff <= cnt_ff + 4'h1;
	end
endmodule

/* bench/tb_top.sv */
`include "sss_consts.vh"

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk, rst, lim, off_req, pin, cfg_wr, a1, i1, a2, i2, ar, ir, ana;
	logic [7:0] vo, io, po, vi, tc, vthr, ithr, pthr, nthr, full;
	logic [23:0] hlim;
	logic [6:0] m1, m2, mr;
	logic [1:0] src;
	logic [3:0] lag;
	wire o1, o2, rel, lg, lv, b1, b2, b3, pen, bst, der;
	wire [15:0] ua;
	wire [6:0] cnd;
	wire [23:0] hrs;
	int err_total, checks_done, k;

	sss_top #(.CYC_PER_HOUR(39'd10), .BLINK_HALF_CYC(4)) u_dut (
		.mclk(mclk), .rst(rst), .vout_pct(vo), .iout_pct(io), .pout_pct(po),
		.vin_pct(vi), .temp_c(tc), .output_overvoltage_limiter(lim),
		.remote_off_pin(pin), .cfg_wr(cfg_wr), .cfg_vout_thr(vthr),
		.cfg_iout_thr(ithr), .cfg_pout_thr(pthr), .cfg_vin_thr(nthr),
		.cfg_hours_lim(hlim), .cfg_out1_mask(m1), .cfg_out1_and(a1),
		.cfg_out1_inv(i1), .cfg_out2_mask(m2), .cfg_out2_and(a2),
		.cfg_out2_inv(i2), .cfg_relay_mask(mr), .cfg_relay_and(ar),
		.cfg_relay_inv(ir), .cfg_out2_analog(ana), .cfg_ana_src(src),
		.cfg_ana_full(full), .out1_ff(o1), .out2_ff(o2), .out2_ua_ff(ua),
		.relay_closed_ff(rel), .output_good_lamp_ff(lg), .lamp_vin_ff(lv),
		.lamp_bar1_ff(b1), .lamp_bar2_ff(b2), .lamp_bar3_ff(b3),
		.power_en_ff(pen), .boost_ff(bst), .derate_ff(der), .cond_ff(cnd),
		.hours_ff(hrs)
	);
	sss_plc u_plc (.mclk(mclk), .off_req(off_req), .lag(lag),
		.remote_off_pin(pin));

	////////////////////////////////////////////////////////////////////
	task automatic print_verdict;
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [23:0] exp,
		input logic [23:0] got);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic meas(input logic [7:0] v, i, p, n, t);
		@(posedge mclk);
		vo <= v;
		io <= i;
		po <= p;
		vi <= n;
		tc <= t;
		wt(3);
	endtask
	task automatic cfg_go;
		@(posedge mclk);
		cfg_wr <= 1'b1;
		@(posedge mclk);
		cfg_wr <= 1'b0;
		wt(2);
	endtask
	task automatic wait_en(input logic v);
		for (k = 0; k < 40 && pen !== v; k++)
			wt(1);
		chk("power enable", v, pen);
		if (k == 40)
			print_verdict;
	endtask

	////////////////////////////////////////////////////////////////////
	task automatic t_hours;
		chk("hours at start", 24'h0, hrs);
		@(posedge mclk);
		hlim <= 24'h000002;
		cfg_go;
		chk("hours cond early", 1'b0, cnd[3]);
		wt(20);
		chk("hours count", 24'h2, hrs);
		chk("hours cond", 1'b1, cnd[3]);
	endtask
	task automatic t_default;
		meas(8'h5A, 8'h32, 8'h28, 8'h50, 8'h19);
		chk("relay", 1'b1, rel);
		chk("out1", 1'b0, o1);
		chk("good lamp", 1'b1, lg);
		chk("vin lamp", 1'b0, lv);
		meas(8'h59, 8'h32, 8'h28, 8'h4F, 8'h19);
		chk("relay low", 1'b0, rel);
		chk("out1 low vin", 1'b1, o1);
		chk("vin lamp lit", 1'b1, lv);
	endtask
	task automatic t_bars;
		logic [7:0] pv [6] = '{8'h32, 8'h33, 8'h4B, 8'h4C, 8'h64, 8'h65};
		foreach (pv[j]) begin
			meas(8'h64, 8'h32, pv[j], 8'h64, 8'h19);
			chk("bars", {pv[j] > 8'h32, pv[j] > 8'h4B, pv[j] > 8'h64},
				{b1, b2, b3});
			chk("boost", pv[j] > 8'h64, bst);
			chk("out2 power", pv[j] > 8'h64, o2);
		end
	endtask
	task automatic t_route;
		@(posedge mclk);
		ithr <= 8'hC8;
		m1 <= 7'h12;
		a1 <= 1'b1;
		m2 <= 7'h02;
		mr <= 7'h02;
		ir <= 1'b1;
		cfg_go;
		meas(8'h64, 8'h97, 8'h28, 8'h64, 8'h32);
		chk("and needs both", 1'b0, o1);
		chk("iout on out2", 1'b1, o2);
		chk("iout on relay", 1'b0, rel);
		meas(8'h64, 8'h96, 8'h28, 8'h64, 8'h37);
		chk("iout clamp", 1'b0, cnd[1]);
		chk("warn", 2'b10, {cnd[4], der});
		meas(8'h64, 8'h97, 8'h28, 8'h64, 8'h3C);
		chk("and met", 1'b1, o1);
		chk("derate", 2'b11, {cnd[4], der});
	endtask
	task automatic t_ana;
		@(posedge mclk);
		ana <= 1'b1;
		src <= `SSS_SRC_POUT;
		cfg_go;
		meas(8'h64, 8'h32, 8'h7D, 8'h64, 8'h19);
		chk("ua full", 16'h4E20, ua);
		chk("out2 analog", 1'b0, o2);
		meas(8'h64, 8'h32, 8'h32, 8'h64, 8'h19);
		chk("ua mid", 16'h28A0, ua);
		meas(8'h64, 8'h32, 8'h00, 8'h64, 8'h19);
		chk("ua zero", 16'h0FA0, ua);
		@(posedge mclk);
		src <= `SSS_SRC_IOUT;
		cfg_go;
		meas(8'h64, 8'h32, 8'h00, 8'h64, 8'h19);
		chk("ua current", 16'h28A0, ua);
		// unsupported source code falls back to voltage
		@(posedge mclk);
		src <= 2'h3;
		cfg_go;
		meas(8'h64, 8'h32, 8'h00, 8'h64, 8'h19);
		chk("ua voltage", 16'h41A0, ua);
	endtask
	task automatic t_blink;
		int n;
		logic p;
		n = 0;
		meas(8'h50, 8'h32, 8'h28, 8'h64, 8'h19);
		p = lg;
		repeat (16) begin
			wt(1);
			n += (lg !== p);
			p = lg;
		end
		chk("blink toggles", 1'b1, n >= 3);
	endtask
	task automatic t_sleep;
		meas(8'h64, 8'h32, 8'h65, 8'h4F, 8'h19);
		@(posedge mclk);
		off_req <= 1'b1;
		wait_en(1'b0);
		wt(1);
		chk("sleep outputs", 24'h0,
			{ua, o1, o2, rel, lg, lv, b1, b2, b3});
		@(posedge mclk);
		off_req <= 1'b0;
		wait_en(1'b1);
		wt(1);
		chk("bars back", 3'b111, {b1, b2, b3});
	endtask
	task automatic t_lim;
		@(posedge mclk);
		lim <= 1'b1;
		wt(8);
		chk("limiter cond", 1'b1, cnd[5]);
		@(posedge mclk);
		lim <= 1'b0;
		wt(8);
		chk("limiter gone", 1'b0, cnd[5]);
	endtask

	////////////////////////////////////////////////////////////////////
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	initial begin
		repeat (20000) @(posedge mclk);
		err_total++;
		print_verdict;
	end
	initial begin
		{rst, cfg_wr} = 2'b10;
		{lim, off_req, lag, ana, src} = 9'h030;
		{vo, io, po, vi, tc} = {8'h64, 8'h32, 8'h28, 8'h64, 8'h19};
		{vthr, ithr, pthr, nthr} = {`SSS_VOUT_THR_DEF, `SSS_IP_THR_DEF,
			`SSS_IP_THR_DEF, `SSS_VIN_THR_DEF};
		{hlim, full} = {`SSS_HOURS_DEF, `SSS_ANA_FULL_DEF};
		{m1, a1, i1} = {`SSS_OUT1_MASK_DEF, 2'b00};
		{m2, a2, i2} = {`SSS_OUT2_MASK_DEF, 2'b00};
		{mr, ar, ir} = {`SSS_RELAY_MASK_DEF, 2'b01};
		err_total = 0;
		checks_done = 0;
		repeat (16) @(posedge mclk);
		rst <= 1'b0;
		wt(1);
		t_hours;
		t_default;
		t_bars;
		t_blink;
		t_sleep;
		t_lim;
		t_route;
		t_ana;
		print_verdict;
	end
endmodule
